/* File: led_backlight_dimming_core.sv */
// Dimming, current scaling, spread spectrum and power sequencing core
// Functional notes
// [RULE_01] Two-bit spread deviation select, reset to 10
// [RULE_02] Two-bit spread modulation rate, reset to 00
// [RULE_03] No spread spectrum under external sync clock
// [RULE_04] Enable low: stop, discharge 400ms, shut down
// [RULE_05] Discharge overvoltage: fault recovery, report fault
// [RULE_06] Skip boost cycles under light load
// [RULE_07] Per-string 12-bit current scale, reset 0xFFF
// [RULE_08] String setup decoded at power-up only
// [RULE_09] Outputs grouped by ones, twos or threes; string code 7 drives all six outputs as one group
// [RULE_10] Phase shift set by string count
// [RULE_11] Dimming period from 20MHz, not input PWM
// [RULE_12] Eight resistor-selected dimming frequencies
// [RULE_13] Internal dimming frequency in phase-shift, hybrid
// [RULE_14] One global brightness from pin or register
// [RULE_15] Brightness source select, defaults to PWM pin
// [RULE_16] Sloper enabled after reset, configurable
// [RULE_17] Mode code gives dimming mode and address
// [RULE_18] Constant neighbour delay in phase-shift mode
// [RULE_19] Sync pin level or clock sets spread spectrum
// [RULE_20] Direct PWM follows input pin
// [RULE_21] Period counter, on-time from scaled brightness
// [RULE_22] Resistor codes sampled once, held until power-up
`timescale 1ns/1ps
module led_backlight_dimming_core #(
   parameter int DISCHARGE_CYCLES = backlight_pkg::DISCHARGE_CYCLES,
   parameter int RECOVERY_CYCLES = backlight_pkg::RECOVERY_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable_pin,
   input wire logic pwm_in,
   input wire logic boost_sync_pin,
   input wire logic [2:0] string_setup_resistor,
   input wire logic [2:0] dimming_freq_resistor,
   input wire logic [2:0] mode_resistor,
   input wire logic discharge_over_ovph,
   input wire logic light_load,
   input wire logic vout_above_target,
   input wire logic reg_write_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_write_data,
   output logic [15:0] reg_read_data,
   output logic [5:0] led_sink_on,
   output logic [71:0] sink_current_codes,
   output logic boost_enable,
   output logic boost_skip_cycle,
   output logic power_fet_on,
   output logic discharge_sink_on,
   output logic fault_recovery,
   output logic boost_high_overvoltage_fault,
   output logic spread_spectrum_on,
   output logic boost_ext_sync_mode,
   output logic [1:0] spread_deviation_sel,
   output logic [1:0] spread_modulation_rate_sel,
   output logic [6:0] i2c_target_address
);
   localparam int NCH = backlight_pkg::NUM_CHANNELS;
   localparam int PB = backlight_pkg::PERIOD_BITS;
   initial begin
      if (DISCHARGE_CYCLES < 1 || RECOVERY_CYCLES < 1) $error("Timing counts must be at least one cycle");
   end
   // ----------------------------------------------------------------
   // Power sequencing and resistor code capture
   // ----------------------------------------------------------------
   backlight_pkg::power_state_t state_reg, state_next;
   logic [31:0] timer_reg, timer_next;
   logic [2:0] string_code_reg, string_code_next;
   logic [2:0] freq_code_reg, freq_code_next;
   logic [2:0] mode_code_reg, mode_code_next;
   logic ovph_flag_reg, ovph_flag_next;
   logic ovph_clear;
   logic active;
   assign ovph_clear = reg_write_en && reg_addr == backlight_pkg::REG_STATUS &&
                       reg_write_data[backlight_pkg::STAT_OVPH_BIT];
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      string_code_next = string_code_reg;
      freq_code_next = freq_code_reg;
      mode_code_next = mode_code_reg;
      // Set wins over a clear in the same cycle
      ovph_flag_next = discharge_over_ovph ? 1'b1 : (ovph_clear ? 1'b0 : ovph_flag_reg); // [RULE_05]
      case (state_reg)
         backlight_pkg::ST_SHUTDOWN: begin
            if (enable_pin) begin
               // Straps only move on the way out of shutdown
               string_code_next = string_setup_resistor; // [RULE_08] [RULE_22]
               freq_code_next = dimming_freq_resistor; // [RULE_22]
               mode_code_next = mode_resistor; // [RULE_22]
               state_next = backlight_pkg::ST_ACTIVE;
            end
         end
         backlight_pkg::ST_ACTIVE: begin
            if (discharge_over_ovph) begin
               state_next = backlight_pkg::ST_RECOVERY; // [RULE_05]
               timer_next = 32'(RECOVERY_CYCLES - 1);
            end else if (!enable_pin) begin
               state_next = backlight_pkg::ST_DISCHARGE; // [RULE_04]
               timer_next = 32'(DISCHARGE_CYCLES - 1);
            end
         end
         backlight_pkg::ST_DISCHARGE: begin
            if (discharge_over_ovph) begin
               state_next = backlight_pkg::ST_RECOVERY; // [RULE_05]
               timer_next = 32'(RECOVERY_CYCLES - 1);
            end else if (timer_reg == 32'h0) begin
               state_next = backlight_pkg::ST_SHUTDOWN; // [RULE_04]
            end else timer_next = timer_reg - 32'h1;
         end
         backlight_pkg::ST_RECOVERY: begin
            if (timer_reg == 32'h0) begin
               state_next = enable_pin ? backlight_pkg::ST_ACTIVE : backlight_pkg::ST_DISCHARGE;
               timer_next = 32'(DISCHARGE_CYCLES - 1);
            end else timer_next = timer_reg - 32'h1;
         end
         default: state_next = backlight_pkg::ST_SHUTDOWN;
      endcase
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= backlight_pkg::ST_SHUTDOWN;
         timer_reg <= 32'h0;
         string_code_reg <= 3'h0;
         freq_code_reg <= 3'h0;
         mode_code_reg <= 3'h0;
         ovph_flag_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         string_code_reg <= string_code_next;
         freq_code_reg <= freq_code_next;
         mode_code_reg <= mode_code_next;
         ovph_flag_reg <= ovph_flag_next;
      end
   end
   assign active = state_reg == backlight_pkg::ST_ACTIVE;
   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [1:0] dev_reg, dev_next;
   logic [1:0] rate_reg, rate_next;
   logic src_reg, src_next;
   logic sloper_reg, sloper_next;
   logic [15:0] brt_reg, brt_next;
   logic [11:0] scale_reg [NCH], scale_next [NCH];
   logic [15:0] rdata_next;
   logic ext_sync;
   always_comb begin
      dev_next = dev_reg;
      rate_next = rate_reg;
      src_next = src_reg;
      sloper_next = sloper_reg;
      brt_next = brt_reg;
      scale_next = scale_reg;
      rdata_next = 16'h0000;
      if (reg_write_en) begin
         case (reg_addr)
            backlight_pkg::REG_SPREAD: begin
               dev_next = reg_write_data[backlight_pkg::SPREAD_DEV_LSB +: 2]; // [RULE_01]
               rate_next = reg_write_data[backlight_pkg::SPREAD_RATE_LSB +: 2]; // [RULE_02]
            end
            backlight_pkg::REG_BRT_CTRL: begin
               src_next = reg_write_data[backlight_pkg::BRT_SRC_BIT]; // [RULE_15]
               sloper_next = reg_write_data[backlight_pkg::SLOPER_EN_BIT]; // [RULE_16]
            end
            backlight_pkg::REG_BRT_VALUE: brt_next = reg_write_data;
            default: ;
         endcase
      end
      case (reg_addr)
         backlight_pkg::REG_SPREAD: rdata_next = {12'h000, rate_reg, dev_reg};
         backlight_pkg::REG_BRT_CTRL: rdata_next = {14'h0000, sloper_reg, src_reg};
         backlight_pkg::REG_BRT_VALUE: rdata_next = brt_reg;
         backlight_pkg::REG_STATUS: rdata_next = {14'h0000, ext_sync, ovph_flag_reg};
         backlight_pkg::REG_CONFIG: rdata_next = {7'h00, mode_code_reg, freq_code_reg, string_code_reg};
         default: ;
      endcase
      // Current scales sit at consecutive indices starting at the base
      for (int i = 0; i < NCH; i++) begin
         if (reg_addr == backlight_pkg::REG_CURRENT_BASE + 4'(i)) begin
            if (reg_write_en) scale_next[i] = reg_write_data[11:0]; // [RULE_07]
            rdata_next = {4'h0, scale_reg[i]};
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dev_reg <= backlight_pkg::SPREAD_DEV_RESET; // [RULE_01]
         rate_reg <= backlight_pkg::SPREAD_RATE_RESET; // [RULE_02]
         src_reg <= 1'b0; // [RULE_15]
         sloper_reg <= 1'b1; // [RULE_16]
         brt_reg <= backlight_pkg::BRT_VALUE_RESET;
         scale_reg <= '{default: backlight_pkg::CURRENT_RESET}; // [RULE_07]
         reg_read_data <= 16'h0000;
      end else begin
         dev_reg <= dev_next;
         rate_reg <= rate_next;
         src_reg <= src_next;
         sloper_reg <= sloper_next;
         brt_reg <= brt_next;
         scale_reg <= scale_next;
         reg_read_data <= rdata_next;
      end
   end
   // ----------------------------------------------------------------
   // Boost sync detection and spread spectrum
   // ----------------------------------------------------------------
   logic sync_prev_reg;
   logic [15:0] since_edge_reg, since_edge_next;
   logic [15:0] last_gap_reg, last_gap_next;
   localparam logic [15:0] SYNC_WIN = 16'(backlight_pkg::SYNC_WINDOW_CYCLES);
   logic sync_edge;
   assign sync_edge = boost_sync_pin != sync_prev_reg;
   always_comb begin
      since_edge_next = sync_edge ? 16'h0 : since_edge_reg + {15'h0, since_edge_reg != 16'hffff};
      last_gap_next = sync_edge ? since_edge_reg : last_gap_reg;
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_prev_reg <= 1'b0;
         since_edge_reg <= 16'hffff;
         last_gap_reg <= 16'hffff;
      end else begin
         sync_prev_reg <= boost_sync_pin;
         since_edge_reg <= since_edge_next;
         last_gap_reg <= last_gap_next;
      end
   end
   // Two close edges in a row mean a clock, not a level change
   assign ext_sync = since_edge_reg < SYNC_WIN && last_gap_reg < SYNC_WIN; // [RULE_19]
   assign boost_ext_sync_mode = ext_sync;
   assign spread_spectrum_on = active && boost_sync_pin && !ext_sync; // [RULE_03] [RULE_19]
   assign spread_deviation_sel = dev_reg; // [RULE_01]
   assign spread_modulation_rate_sel = rate_reg; // [RULE_02]
   assign boost_enable = active; // [RULE_04]
   assign boost_skip_cycle = active && light_load && vout_above_target; // [RULE_06]
   assign power_fet_on = active; // [RULE_04]
   assign discharge_sink_on = state_reg == backlight_pkg::ST_DISCHARGE; // [RULE_04]
   assign fault_recovery = state_reg == backlight_pkg::ST_RECOVERY; // [RULE_05]
   assign boost_high_overvoltage_fault = ovph_flag_reg; // [RULE_05]
   assign i2c_target_address = mode_code_reg[2] ? backlight_pkg::I2C_ADDR_UPPER :
                               backlight_pkg::I2C_ADDR_LOWER; // [RULE_17]
   // ----------------------------------------------------------------
   // 20 MHz tick, input duty measurement and sloper
   // ----------------------------------------------------------------
   logic [2:0] div_reg, div_next;
   logic tick, win_end;
   logic [15:0] win_reg, win_next, hi_cnt_reg, hi_cnt_next, hi_sum;
   logic [15:0] duty_reg, duty_next, slope_reg, slope_next, target;
   assign tick = div_reg == 3'(backlight_pkg::OSC_DIVIDE - 1);
   assign target = src_reg ? brt_reg : duty_reg; // [RULE_14] [RULE_15]
   // Duty is the high-tick count over a fixed 65535-tick window: no divider,
   // at the cost of a few ms of lag behind the pin
   assign win_end = tick && win_reg == 16'hfffe;
   assign hi_sum = hi_cnt_reg + {15'h0, pwm_in};
   always_comb begin
      div_next = tick ? 3'h0 : div_reg + 3'h1;
      win_next = win_reg;
      hi_cnt_next = hi_cnt_reg;
      duty_next = win_end ? hi_sum : duty_reg; // [RULE_14]
      slope_next = slope_reg;
      if (tick) begin
         win_next = win_end ? 16'h0 : win_reg + 16'h1;
         hi_cnt_next = win_end ? 16'h0 : hi_sum;
         if (!sloper_reg || slope_reg == target) slope_next = target; // [RULE_16]
         else if (slope_reg < target) slope_next = slope_reg + 16'h1; // [RULE_16]
         else slope_next = slope_reg - 16'h1; // [RULE_16]
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_reg <= 3'h0;
         win_reg <= 16'h0;
         hi_cnt_reg <= 16'h0;
         duty_reg <= 16'h0;
         slope_reg <= 16'h0;
      end else begin
         div_reg <= div_next;
         win_reg <= win_next;
         hi_cnt_reg <= hi_cnt_next;
         duty_reg <= duty_next;
         slope_reg <= slope_next;
      end
   end
   // ----------------------------------------------------------------
   // Dimming mode, period counter and channel outputs
   // ----------------------------------------------------------------
   backlight_pkg::dim_mode_t mode;
   logic [15:0] pwm_duty, analog_level;
   logic pwm_full;
   logic [PB-1:0] period, on_count;
   logic [PB-1:0] cnt_reg, cnt_next;
   logic [2:0] ngroups;
   logic [5:0] sink_next;
   logic [71:0] codes_next;
   assign mode = backlight_pkg::dim_mode_t'(mode_code_reg[1:0]); // [RULE_17]
   assign period = PB'(1) << (5'd17 - {2'b00, freq_code_reg}); // [RULE_12]
   assign on_count = PB'({pwm_duty, 1'b0} >> freq_code_reg); // [RULE_21]
   always_comb begin
      pwm_duty = slope_reg;
      analog_level = backlight_pkg::FULL_BRIGHTNESS;
      // Hybrid: analog above the threshold, PWM times eight below it
      pwm_full = mode == backlight_pkg::DIM_CURRENT ||
                 (mode == backlight_pkg::DIM_HYBRID && slope_reg >= backlight_pkg::HYBRID_THRESHOLD);
      if (pwm_full) analog_level = slope_reg;
      else if (mode == backlight_pkg::DIM_HYBRID) begin
         pwm_duty = {slope_reg[12:0], 3'b000};
         analog_level = backlight_pkg::HYBRID_THRESHOLD;
      end
      case (string_code_reg)
         3'd0: ngroups = 3'd6;
         3'd1: ngroups = 3'd5;
         3'd2: ngroups = 3'd4;
         3'd3: ngroups = 3'd3;
         3'd4: ngroups = 3'd2;
         3'd5: ngroups = 3'd3;
         3'd6: ngroups = 3'd2;
         default: ngroups = 3'd1;
      endcase
      cnt_next = cnt_reg;
      if (tick) begin
         cnt_next = (cnt_reg >= period - PB'(1)) ? PB'(0) : cnt_reg + PB'(1); // [RULE_11] [RULE_21]
      end
      sink_next = 6'h00;
      codes_next = 72'h0;
      for (int i = 0; i < NCH; i++) begin
         logic [2:0] grp;
         logic [PB-1:0] offset, delta;
         logic [27:0] cur;
         grp = 3'd0;
         offset = PB'(0);
         delta = PB'(0);
         cur = 28'h0;
         case (string_code_reg)
            3'd5: grp = 3'(i / 2); // [RULE_09]
            3'd6: grp = 3'(i / 3); // [RULE_09]
            3'd7: grp = 3'd0; // [RULE_09]
            default: grp = 3'(i);
         endcase
         // Neighbour delay is one period over the group count
         offset = PB'((21'(period) * 21'(grp)) / 21'(ngroups)); // [RULE_10] [RULE_18]
         delta = (cnt_reg >= offset) ? cnt_reg - offset : cnt_reg + period - offset;
         if (active && grp < ngroups) begin
            if (mode == backlight_pkg::DIM_DIRECT) begin
               sink_next[i] = pwm_in; // [RULE_20]
            end else begin
               sink_next[i] = pwm_full || delta < on_count; // [RULE_13] [RULE_18] [RULE_21]
            end
            cur = 28'(scale_reg[i]) * 28'(analog_level);
            codes_next[i*12 +: 12] = (analog_level == backlight_pkg::FULL_BRIGHTNESS) ?
                                     scale_reg[i] : cur[27:16]; // [RULE_07]
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= PB'(0);
         led_sink_on <= 6'h00;
         sink_current_codes <= 72'h0;
      end else begin
         cnt_reg <= cnt_next;
         led_sink_on <= sink_next;
         sink_current_codes <= codes_next;
      end
   end
endmodule // led_backlight_dimming_core

/* File: backlight_pkg.sv */
// Shared constants for the LED backlight dimming core
package backlight_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_DIVIDE = 5;
   localparam int DISCHARGE_TIME_MS = 400;
   localparam int DISCHARGE_CYCLES = DISCHARGE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RECOVERY_TIME_MS = 100;
   localparam int RECOVERY_CYCLES = RECOVERY_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SYNC_MIN_FREQ_KHZ = 100;
   localparam int SYNC_WINDOW_CYCLES = 1000000 / (SYNC_MIN_FREQ_KHZ * CLK_PERIOD_NS);
   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_SPREAD = 4'h0;
   localparam logic [3:0] REG_BRT_CTRL = 4'h1;
   localparam logic [3:0] REG_BRT_VALUE = 4'h2;
   localparam logic [3:0] REG_CURRENT_BASE = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h9;
   localparam logic [3:0] REG_CONFIG = 4'ha;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int SPREAD_DEV_LSB = 0;
   localparam int SPREAD_RATE_LSB = 2;
   localparam int BRT_SRC_BIT = 0;
   localparam int SLOPER_EN_BIT = 1;
   localparam int STAT_OVPH_BIT = 0;
   localparam int STAT_EXT_SYNC_BIT = 1;
   localparam logic [1:0] SPREAD_DEV_RESET = 2'h2;
   localparam logic [1:0] SPREAD_RATE_RESET = 2'h0;
   localparam logic [11:0] CURRENT_RESET = 12'hfff;
   localparam logic [15:0] BRT_VALUE_RESET = 16'h0000;
   localparam logic [15:0] HYBRID_THRESHOLD = 16'h2000;
   localparam logic [15:0] FULL_BRIGHTNESS = 16'hffff;
   localparam logic [6:0] I2C_ADDR_LOWER = 7'h2b;
   localparam logic [6:0] I2C_ADDR_UPPER = 7'h2a;
   localparam int NUM_CHANNELS = 6;
   localparam int PERIOD_BITS = 18;
   // ----------------------------------------------------------------
   // Modes and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DIM_PHASE_SHIFT,
      DIM_HYBRID,
      DIM_CURRENT,
      DIM_DIRECT
   } dim_mode_t;
   typedef enum {
      ST_SHUTDOWN,
      ST_ACTIVE,
      ST_DISCHARGE,
      ST_RECOVERY
   } power_state_t;
endpackage

/* File: led_backlight_dimming_core_assertions.sv */
// Port-level assertion checker for the LED backlight dimming core
`timescale 1ns/1ps
module led_backlight_dimming_core_assertions (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable_pin,
   input wire logic boost_sync_pin,
   input wire logic discharge_over_ovph,
   input wire logic light_load,
   input wire logic vout_above_target,
   input wire logic reg_write_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_write_data,
   input wire logic boost_enable,
   input wire logic boost_skip_cycle,
   input wire logic power_fet_on,
   input wire logic discharge_sink_on,
   input wire logic fault_recovery,
   input wire logic boost_high_overvoltage_fault,
   input wire logic spread_spectrum_on,
   input wire logic boost_ext_sync_mode,
   input wire logic [1:0] spread_deviation_sel,
   input wire logic [1:0] spread_modulation_rate_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_dev_reset; $fell(reset) |-> spread_deviation_sel == 2'h2 && spread_modulation_rate_sel == 2'h0; endproperty
   a_dev_reset: assert property (p_dev_reset) else $error("spread reset value wrong");
   property p_ss_write; logic [3:0] v; (reg_write_en && reg_addr == 4'h0, v = reg_write_data[3:0])
      |=> {spread_modulation_rate_sel, spread_deviation_sel} == v; endproperty
   a_ss_write: assert property (p_ss_write) else $error("spread fields not stored");
   property p_ss_ext; boost_ext_sync_mode |-> !spread_spectrum_on; endproperty
   a_ss_ext: assert property (p_ss_ext) else $error("spread on under external sync");
   property p_ss_low; !boost_sync_pin |-> !spread_spectrum_on; endproperty
   a_ss_low: assert property (p_ss_low) else $error("spread on with sync pin low");
   property p_skip; boost_enable && light_load && vout_above_target |-> boost_skip_cycle; endproperty
   a_skip: assert property (p_skip) else $error("no skip under light load");
   property p_disc; boost_enable && !enable_pin && !discharge_over_ovph
      |=> discharge_sink_on && !boost_enable && !power_fet_on; endproperty
   a_disc: assert property (p_disc) else $error("enable low did not start discharge");
   property p_disc_hold; $rose(discharge_sink_on) |-> discharge_sink_on [*8]; endproperty
   a_disc_hold: assert property (p_disc_hold) else $error("discharge cut short");
   property p_ovph; boost_enable && discharge_over_ovph |=> fault_recovery && boost_high_overvoltage_fault; endproperty
   a_ovph: assert property (p_ovph) else $error("overvoltage not handled");
   c_disc: cover property ($rose(discharge_sink_on));
   c_rec: cover property ($rose(fault_recovery));
   c_sync: cover property ($rose(boost_ext_sync_mode));
endmodule // led_backlight_dimming_core_assertions
bind led_backlight_dimming_core led_backlight_dimming_core_assertions chk (.*);

/* File: boost_stage_model.sv */
// Behavioural boost stage and LED strings facing the core
`timescale 1ns/1ps
module boost_stage_model (
   input wire logic clk,
   input wire logic boost_enable,
   input wire logic boost_skip_cycle,
   input wire logic [5:0] led_sink_on,
   input wire logic inject_ovph,
   output logic discharge_over_ovph,
   output logic light_load,
   output logic vout_above_target
);
   // Unloaded output creeps up while switching, sags on a skip
   initial vout_above_target = 1'b0;
   always @(posedge clk) vout_above_target <= boost_enable && !boost_skip_cycle && led_sink_on == 6'h0;
   assign light_load = boost_enable && led_sink_on == 6'h0;
   assign discharge_over_ovph = inject_ovph;
endmodule // boost_stage_model

/* File: tb_led_backlight_dimming_core.sv */
// Self-checking bench for the LED backlight dimming core
`timescale 1ns/1ps
module tb_led_backlight_dimming_core;
   typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] r;} row_t;
   logic clk, reset, enable_pin, pwm_in, boost_sync_pin, reg_write_en, inject_ovph;
   logic discharge_over_ovph, light_load, vout_above_target, boost_enable, boost_skip_cycle, power_fet_on;
   logic discharge_sink_on, fault_recovery, boost_high_overvoltage_fault, spread_spectrum_on, boost_ext_sync_mode;
   logic [2:0] string_setup_resistor, dimming_freq_resistor, mode_resistor;
   logic [3:0] reg_addr;
   logic [15:0] reg_write_data, reg_read_data;
   logic [5:0] led_sink_on;
   logic [71:0] sink_current_codes;
   logic [1:0] spread_deviation_sel, spread_modulation_rate_sel;
   logic [6:0] i2c_target_address;
   int num_errors = 0, checks_done = 0, cycles = 0, n;
   row_t rows [9] = '{'{4'h0, 16'h0000, 16'h0000}, '{4'h0, 16'h0005, 16'h0005}, '{4'h0, 16'h000a, 16'h000a},
      '{4'h0, 16'hffff, 16'h000f}, '{4'h1, 16'hffff, 16'h0003}, '{4'h3, 16'hf123, 16'h0123},
      '{4'h8, 16'h0abc, 16'h0abc}, '{4'hb, 16'hffff, 16'h0000}, '{4'ha, 16'hffff, 16'h0138}};
   led_backlight_dimming_core #(.DISCHARGE_CYCLES(20), .RECOVERY_CYCLES(10)) dut (.*);
   boost_stage_model far_side (.clk(clk), .boost_enable(boost_enable), .boost_skip_cycle(boost_skip_cycle),
      .led_sink_on(led_sink_on), .inject_ovph(inject_ovph), .discharge_over_ovph(discharge_over_ovph),
      .light_load(light_load), .vout_above_target(vout_above_target));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge clk);
      reg_addr <= a;
      reg_write_data <= w;
      reg_write_en <= 1'b1;
      @(posedge clk);
      reg_write_en <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] r);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      #1;
      chk(reg_read_data, r);
   endtask
   // One full 1024-tick dimming period at the fastest frequency code
   task automatic count_on(input int ch, output int k);
      k = 0;
      repeat (5120) begin
         @(posedge clk);
         #1;
         if (led_sink_on[ch] === 1'b1) k++;
      end
   endtask
   initial begin
      reset = 1'b1;
      enable_pin = 1'b1;
      pwm_in = 1'b0;
      boost_sync_pin = 1'b0;
      inject_ovph = 1'b0;
      string_setup_resistor = 3'h0;
      dimming_freq_resistor = 3'h7;
      mode_resistor = 3'h4;
      reg_write_en = 1'b0;
      reg_addr = 4'h0;
      reg_write_data = 16'h0000;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r);
         if (rows[i].a == 4'h0) chk({spread_modulation_rate_sel, spread_deviation_sel}, rows[i].w[3:0]);
      end
      // ----------------------------------------------------------------
      // Second reset, then the awkward cases
      // ----------------------------------------------------------------
      reset <= 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(4'h0, 16'h0002);
      rd(4'h1, 16'h0002);
      for (int k = 3; k < 9; k++) rd(k[3:0], 16'h0fff);
      chk(i2c_target_address, 7'h2a);
      string_setup_resistor <= 3'h5;
      rd(4'ha, 16'h0138);
      wr(4'h1, 16'h0001);
      wr(4'h2, 16'h0000);
      wr(4'h3, 16'h0123);
      count_on(0, n);
      count_on(0, n);
      chk(n, 0);
      wr(4'h2, 16'h8000);
      count_on(0, n);
      count_on(0, n);
      chk(n, 2560);
      count_on(5, n);
      chk(n, 2560);
      chk(sink_current_codes[23:0], 24'hfff123);
      boost_sync_pin <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(spread_spectrum_on, 1'b1);
      repeat (10) begin
         repeat (50) @(posedge clk);
         boost_sync_pin <= ~boost_sync_pin;
      end
      #1;
      chk({boost_ext_sync_mode, spread_spectrum_on}, 2'h2);
      boost_sync_pin <= 1'b0;
      repeat (1500) @(posedge clk);
      #1;
      chk({boost_ext_sync_mode, spread_spectrum_on}, 2'h0);
      inject_ovph <= 1'b1;
      @(posedge clk);
      inject_ovph <= 1'b0;
      @(posedge clk);
      #1;
      chk({fault_recovery, boost_high_overvoltage_fault, boost_enable, power_fet_on}, 4'hc);
      rd(4'h9, 16'h0001);
      wr(4'h9, 16'h0001);
      rd(4'h9, 16'h0000);
      // Enable comes back mid-discharge and must be ignored
      enable_pin <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (discharge_sink_on === 1'b1) n++;
         if (n == 5) enable_pin <= 1'b1;
      end
      chk(n, 20);
      rd(4'ha, 16'h013d);
      end_of_test();
   end
endmodule // tb_led_backlight_dimming_core
